// file: verification/bss_host_model.sv
// host model: acknowledges status messages after a chosen delay
// assumes a message stands until acknowledged
`timescale 1ns/10ps
module bss_host_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic msg_valid,
    input wire logic [2:0] msg_code,
    input wire logic [7:0] ack_delay,
    output logic msg_ack,
    output logic [2:0] last_code,
    output logic [7:0] msg_count
);
    logic [7:0] wait_cnt;

    // hold ack up to the edge that takes it, record the code there
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            msg_ack <= 1'b0;
            wait_cnt <= 8'h00;
            last_code <= 3'h0;
            msg_count <= 8'h00;
        end else if (msg_ack && msg_valid) begin
            msg_ack <= 1'b0;
            last_code <= msg_code;
            msg_count <= msg_count + 8'h01;
            wait_cnt <= 8'h00;
        end else if (msg_valid && wait_cnt >= ack_delay) begin
            msg_ack <= 1'b1;
        end else if (msg_valid) begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule

// file: verification/bss_sup_monitor.sv
// port checker bound onto the bias supervisor
// assumes the synchronous reset rst and the comparator lane order
`timescale 1ns/10ps
module bss_sup_monitor #(
    parameter int unsigned OE_LOW_CYC = 20,
    parameter int unsigned BIAS_TIMEOUT_CYC = 50
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [10:0] cmp_raw,
    input wire logic oe_pin,
    input wire logic wake_event,
    input wire logic [2:0] msg_code,
    input wire logic msg_valid,
    input wire logic msg_ack,
    input wire logic pump_enable,
    input wire logic bias_reg_enable,
    input wire logic gate_drive_enable,
    input wire logic ldo_enable,
    input wire logic ldo_pulldown_enable,
    input wire logic messaging_enable,
    input wire logic fault_oe_n
);
    int unsigned bias_cnt;
    int unsigned oe_low_cnt;

    // bias start-up and oe low run lengths
    always_ff @(posedge clk_sys) begin
        if (rst || !bias_reg_enable || gate_drive_enable)
            bias_cnt <= 0;
        else if (bias_cnt < 1000)
            bias_cnt <= bias_cnt + 1;
        if (rst || oe_pin)
            oe_low_cnt <= 0;
        else if (oe_low_cnt < 1000)
            oe_low_cnt <= oe_low_cnt + 1;
    end

    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // level held past synchroniser and flags
    sequence s_held(sig);
        sig [*5];
    endsequence
    property p_pump_low;
        s_held(cmp_raw[0] && !cmp_raw[1]) ##0 bias_reg_enable |-> pump_enable;
    endproperty
    property p_supply_undervoltage_lockout_off;
        s_held(cmp_raw[2]) |->
            !gate_drive_enable && !pump_enable && !bias_reg_enable;
    endproperty
    property p_supply_overvoltage_lockout_pin;
        s_held(cmp_raw[3]) |-> !fault_oe_n;
    endproperty
    property p_msg_hold;
        msg_valid && !msg_ack && messaging_enable |=>
            (msg_valid && $stable(msg_code)) || !messaging_enable;
    endproperty
    property p_severe;
        s_held(cmp_raw[4]) |->
            !ldo_enable && ldo_pulldown_enable && !gate_drive_enable;
    endproperty
    property p_latch;
        s_held(ldo_pulldown_enable && !cmp_raw[5] && !wake_event)
            |=> !ldo_enable;
    endproperty
    property p_persist;
        s_held(cmp_raw[3] && !fault_oe_n) |=> !fault_oe_n;
    endproperty
    property p_timeout;
        bias_cnt <= BIAS_TIMEOUT_CYC + 4;
    endproperty
    property p_oe_low;
        oe_low_cnt > OE_LOW_CYC + 4 |-> !bias_reg_enable && !gate_drive_enable;
    endproperty
    a_pump_low: assert property (p_pump_low)
        else $error("pump off");
    a_supply_undervoltage_lockout_off: assert property (p_supply_undervoltage_lockout_off)
        else $error("drive on");
    a_supply_overvoltage_lockout_pin: assert property (p_supply_overvoltage_lockout_pin)
        else $error("pin released");
    a_msg_hold: assert property (p_msg_hold)
        else $error("msg dropped");
    a_severe: assert property (p_severe)
        else $error("ldo on");
    a_latch: assert property (p_latch)
        else $error("ldo back");
    a_persist: assert property (p_persist)
        else $error("pin cleared");
    a_timeout: assert property (p_timeout)
        else $error("bias overrun");
    a_oe_low: assert property (p_oe_low)
        else $error("bias on");
endmodule

bind bss_bias_supervisor bss_sup_monitor #(
    .OE_LOW_CYC(OE_LOW_CYC),
    .BIAS_TIMEOUT_CYC(BIAS_TIMEOUT_CYC)
) u_mon (.*);

// file: verification/tb.sv
// self-checking bench for the bias supervisor
// assumes shortened counts: oe low 20, bias time-out 50, ldo delay 30
`timescale 1ns/10ps
module tb;
    localparam int RDY = 0, MSG = 1, PUMP = 2, BYP = 3, BIAS = 4;
    localparam int GATE = 5, LDO = 6, PD = 7, FLT = 8;
    logic clk_sys, rst, oe_pin, wake_event, reg_write, reg_read;
    logic [10:0] cmp_raw;
    logic [7:0] reg_addr, ack_delay, msg_count;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0] msg_code, last_code;
    logic msg_valid, msg_ack, pump_enable, pump_bypass, bias_reg_enable;
    logic gate_drive_enable, ldo_enable, ldo_pulldown_enable;
    logic messaging_enable, bias_rail_ready_flag, fault_oe_n, fault_out;
    wire logic [8:0] outs;
    int n_fail = 0;
    int checks_done = 0;

    assign outs = {fault_oe_n, ldo_pulldown_enable, ldo_enable,
        gate_drive_enable, bias_reg_enable, pump_bypass, pump_enable,
        messaging_enable, bias_rail_ready_flag};

    bss_bias_supervisor #(.OE_LOW_CYC(20), .BIAS_TIMEOUT_CYC(50),
        .LDO_OFF_CYC(30)) uut (
        .clk_sys, .rst, .cmp_raw, .oe_pin, .wake_event, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .msg_code, .msg_valid, .msg_ack,
        .pump_enable, .pump_bypass, .bias_reg_enable, .gate_drive_enable,
        .ldo_enable, .ldo_pulldown_enable, .messaging_enable,
        .bias_rail_ready_flag, .fault_out, .fault_oe_n);
    bss_host_model host (.clk_sys, .rst, .msg_valid, .msg_code, .ack_delay,
        .msg_ack, .last_code, .msg_count);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_out(input int idx, input logic val, input int lim);
        for (int i = 0; i < lim && outs[idx] !== val; i++)
            cyc(1);
        chk({31'h0, outs[idx]}, {31'h0, val});
    endtask
    task automatic wait_msg(input logic [2:0] code);
        logic [7:0] n0;
        n0 = msg_count;
        for (int i = 0; i < 60 && msg_count === n0; i++)
            cyc(1);
        chk({24'h0, msg_count}, {24'h0, n0 + 8'h01});
        chk({29'h0, last_code}, {29'h0, code});
    endtask
    task automatic setc(input int idx, input logic val);
        @(posedge clk_sys);
        cmp_raw[idx] <= val;
    endtask
    task automatic set_oe(input logic val);
        @(posedge clk_sys);
        oe_pin <= val;
    endtask
    task automatic oe_pulse();
        set_oe(1'b0);
        cyc(4);
        set_oe(1'b1);
        cyc(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_start();
        wait_out(GATE, 1'b1, 100);
        wait_out(RDY, 1'b1, 0);
        wait_out(PUMP, 1'b1, 0);
        wait_out(BYP, 1'b0, 0);
        rd_chk(bss_pkg::REG_CTRL, 32'hFFFF_FFFF, 32'h0);
        rd_chk(bss_pkg::REG_STATE, 32'h1FF, {23'h0, 1'b1, bss_pkg::ST_ACTIVE});
        wr(8'h40, 32'hFFFF_FFFF);
        rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0);
        setc(0, 1'b0);
        setc(1, 1'b1);
        wait_out(PUMP, 1'b0, 10);
        wait_out(BYP, 1'b1, 0);
        setc(1, 1'b0);
        setc(0, 1'b1);
        wait_out(PUMP, 1'b1, 10);
    endtask
    task automatic t_standby();
        set_oe(1'b0);
        cyc(12);
        wait_out(BIAS, 1'b1, 0);
        wait_out(BIAS, 1'b0, 20);
        wait_out(LDO, 1'b1, 0); // ldo kept in standby
        rd_chk(bss_pkg::REG_STATE, 32'hFF, {24'h0, bss_pkg::ST_STANDBY});
        setc(7, 1'b0);
        cyc(3);
        set_oe(1'b1);
        cyc(40);
        wait_out(GATE, 1'b0, 0);
        wait_out(GATE, 1'b1, 30);
        setc(7, 1'b1);
    endtask
    task automatic t_lockout(input int lane, input logic [7:0] sreg,
        input int b, input logic [2:0] code);
        setc(lane, 1'b1);
        wait_out(GATE, 1'b0, 10);
        wait_out(PUMP, 1'b0, 0);
        wait_out(BIAS, 1'b0, 0);
        wait_out(FLT, 1'b0, 0);
        chk({31'h0, fault_out}, 32'h0);
        wait_out(LDO, 1'b1, 0);
        wait_msg(code);
        oe_pulse();
        cyc(6);
        rd_chk(sreg, 32'h1 << b, 32'h1 << b);
        setc(lane, 1'b0);
        cyc(4);
        oe_pulse();
        wait_out(GATE, 1'b1, 80);
        wait_out(FLT, 1'b1, 0);
        rd_chk(sreg, 32'h1 << b, 32'h0);
    endtask
    task automatic t_warn();
        setc(10, 1'b1);
        wait_msg(3'h5);
        wait_out(GATE, 1'b1, 0);
        wait_out(FLT, 1'b1, 0);
        rd_chk(bss_pkg::REG_STATUS0, 32'h30, 32'h10);
        setc(10, 1'b0);
        cyc(4);
        oe_pulse();
    endtask
    task automatic t_supply_undervoltage_lockout();
        setc(5, 1'b0);
        setc(2, 1'b1);
        wait_out(LDO, 1'b0, 10);
        wait_msg(3'h1);
        setc(2, 1'b0);
        cyc(10);
        wait_out(LDO, 1'b0, 0);
        setc(5, 1'b1);
        wait_out(LDO, 1'b1, 10);
        oe_pulse();
        wait_out(GATE, 1'b1, 80);
    endtask
    task automatic t_sleep();
        wr(bss_pkg::REG_CTRL, 32'h1);
        rd_chk(bss_pkg::REG_CTRL, 32'h1, 32'h1);
        set_oe(1'b0);
        wait_out(LDO, 1'b0, 40);
        wait_out(PD, 1'b1, 0);
        wait_out(BIAS, 1'b0, 0);
        @(posedge clk_sys);
        wake_event <= 1'b1;
        @(posedge clk_sys);
        wake_event <= 1'b0;
        wait_out(LDO, 1'b1, 40);
        rd_chk(bss_pkg::REG_CTRL, 32'h1, 32'h0);
        set_oe(1'b1);
        wait_out(GATE, 1'b1, 100);
    endtask
    task automatic t_overtemp();
        setc(9, 1'b0);
        setc(8, 1'b1);
        wait_msg(3'h0);
        wait_out(GATE, 1'b0, 0);
        wait_out(BIAS, 1'b0, 0);
        cyc(20);
        wait_out(LDO, 1'b1, 0);
        wait_out(LDO, 1'b0, 20);
        set_oe(1'b0);
        wait_out(MSG, 1'b0, 8);
        set_oe(1'b1);
        cyc(10);
        wait_out(GATE, 1'b0, 0);
        setc(8, 1'b0);
        setc(9, 1'b1);
        cyc(4);
        oe_pulse();
        wait_out(GATE, 1'b1, 80);
    endtask
    task automatic t_severe();
        setc(5, 1'b0);
        setc(4, 1'b1);
        wait_out(PD, 1'b1, 10);
        wait_out(LDO, 1'b0, 0);
        wait_out(GATE, 1'b0, 0);
        setc(4, 1'b0);
        cyc(20);
        wait_out(LDO, 1'b0, 0);
        setc(5, 1'b1);
        wait_out(LDO, 1'b1, 30);
    endtask

    task automatic finish_test();
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        oe_pin = 1'b1;
        wake_event = 1'b0;
        cmp_raw = 11'h2A1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        ack_delay = 8'h02;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_start();
        t_standby();
        t_lockout(3, bss_pkg::REG_STATUS0, 3, 3'h2);
        t_lockout(6, bss_pkg::REG_STATUS1, 0, 3'h3);
        t_warn();
        t_supply_undervoltage_lockout();
        t_sleep();
        ack_delay <= 8'h14;
        t_overtemp();
        t_severe();
        finish_test();
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        finish_test();
    end
endmodule

// file: verilog/bss_bias_supervisor.sv
// bias supervisor and sequencer: pump, bias rail, host ldo, faults, messages
// assumes comparator levels are asynchronous, oe and wake are synchronous,
// and an external link transmitter acknowledges each message
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
module bss_bias_supervisor #(
    parameter int unsigned OE_LOW_CYC = bss_pkg::OE_LOW_CYC,
    parameter int unsigned BIAS_TIMEOUT_CYC = bss_pkg::BIAS_TIMEOUT_CYC,
    parameter int unsigned LDO_OFF_CYC = bss_pkg::LDO_OFF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [10:0] cmp_raw,
    input wire logic oe_pin,
    input wire logic wake_event,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic [2:0] msg_code,
    output logic msg_valid,
    input wire logic msg_ack,
    output logic pump_enable,
    output logic pump_bypass,
    output logic bias_reg_enable,
    output logic gate_drive_enable,
    output logic ldo_enable,
    output logic ldo_pulldown_enable,
    output logic messaging_enable,
    output logic bias_rail_ready_flag,
    output logic fault_out,
    output logic fault_oe_n
);
    localparam int unsigned TW = bss_pkg::TIMER_W;
    localparam int unsigned NE = bss_pkg::NUM_EVT;

    initial begin
        if (OE_LOW_CYC == 0 || BIAS_TIMEOUT_CYC == 0 || LDO_OFF_CYC == 0 ||
            OE_LOW_CYC >= 2**TW || BIAS_TIMEOUT_CYC >= 2**TW ||
            LDO_OFF_CYC >= 2**TW) begin
            $error("bss_bias_supervisor: timing count out of range");
        end
    end

    // lowest set bit of an event vector as a message code
    function automatic logic [2:0] first_set(input logic [5:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // saturating timer step
    function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction

    // ****************************************************************
    // comparator synchronisation
    // ****************************************************************
    bss_cmp_if #(.WIDTH(bss_pkg::NUM_CMP)) cmp_bus ();
    assign cmp_bus.raw = cmp_raw;

    // comparators pass two flops before any use
    bss_cmp_sync #(.WIDTH(bss_pkg::NUM_CMP)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .cmp(cmp_bus)
    );

    wire logic [10:0] s = cmp_bus.sync;
    wire logic s_severe = s[bss_pkg::CMP_SEVERE_UV];
    wire logic s_release = s[bss_pkg::CMP_ABOVE_RELEASE];
    wire logic s_ready = s[bss_pkg::CMP_BIAS_READY];
    wire logic s_hot = s[bss_pkg::CMP_OVER_TEMP];
    wire logic s_cool = s[bss_pkg::CMP_TEMP_COOL];

    // ****************************************************************
    // state and timers
    // ****************************************************************
    bss_pkg::bss_state_t state;
    bss_pkg::bss_state_t next_state;
    logic [TW-1:0] timer;
    logic [TW-1:0] oe_low_cnt;
    logic oe_prev;
    logic sleep_cfg;
    logic pump_run;
    logic ldo_uv_off;
    logic [5:0] flags;
    logic [5:0] pend;

    wire logic oe_rise = oe_pin & ~oe_prev;
    wire logic oe_low_long = oe_low_cnt >= TW'(OE_LOW_CYC);
    wire logic bias_timeout = timer >= TW'(BIAS_TIMEOUT_CYC);
    wire logic in_ot = state == bss_pkg::ST_OVER_TEMP;
    wire logic ot_msg_busy = msg_valid && msg_code == 3'(bss_pkg::EVT_OVER_TEMP);
    wire logic ot_sent = in_ot && !pend[bss_pkg::EVT_OVER_TEMP] && !ot_msg_busy;
    wire logic ldo_ot_off = ot_sent && timer >= TW'(LDO_OFF_CYC);
    wire logic lockout = |(flags & bss_pkg::LOCKOUT_MASK);
    wire logic run_state = state == bss_pkg::ST_BIAS_UP ||
                           state == bss_pkg::ST_ACTIVE;
    wire logic can_hot = state == bss_pkg::ST_LDO_UP ||
                         state == bss_pkg::ST_STANDBY || run_state;
    wire bss_pkg::bss_state_t low_target =
        sleep_cfg ? bss_pkg::ST_SLEEP : bss_pkg::ST_STANDBY;

    // sequencer transitions
    always_comb begin
        next_state = state;
        case (state)
            bss_pkg::ST_POR: begin
                next_state = bss_pkg::ST_LDO_UP;
            end
            bss_pkg::ST_LDO_UP: begin
                if (!s[bss_pkg::CMP_LDO_UV]) begin
                    next_state = oe_pin ? bss_pkg::ST_BIAS_UP
                                        : bss_pkg::ST_STANDBY;
                end
            end
            bss_pkg::ST_STANDBY: begin
                if (oe_pin) begin
                    next_state = bss_pkg::ST_BIAS_UP;
                end else if (sleep_cfg && oe_low_long) begin
                    next_state = bss_pkg::ST_SLEEP;
                end
            end
            bss_pkg::ST_BIAS_UP: begin
                if (oe_low_long) begin
                    next_state = low_target;
                end else if (s_ready || bias_timeout) begin
                    next_state = bss_pkg::ST_ACTIVE;
                end
            end
            bss_pkg::ST_ACTIVE: begin
                if (oe_low_long) begin
                    next_state = low_target;
                end
            end
            bss_pkg::ST_OVER_TEMP: begin
                if (oe_rise && s_cool && !s_hot) begin
                    next_state = bss_pkg::ST_BIAS_UP;
                end
            end
            bss_pkg::ST_SLEEP: begin
                if (wake_event) begin
                    next_state = bss_pkg::ST_POR;
                end
            end
            bss_pkg::ST_SHUTDOWN: begin
                if (s_release && !s_severe) begin
                    next_state = bss_pkg::ST_POR;
                end
            end
            default: begin
                next_state = bss_pkg::ST_POR;
            end
        endcase
        if (s_severe && state != bss_pkg::ST_SHUTDOWN) begin
            next_state = bss_pkg::ST_SHUTDOWN;
        end else if (s_hot && can_hot) begin
            next_state = bss_pkg::ST_OVER_TEMP;
        end
    end

    // state register and timers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= bss_pkg::ST_POR;
            timer <= '0;
            oe_low_cnt <= '0;
            oe_prev <= 1'b1; // no false rise after reset
        end else begin
            state <= next_state;
            timer <= (next_state != state || (in_ot && !ot_sent)) ? '0
                     : sat_inc(timer);
            oe_low_cnt <= oe_pin ? '0 : sat_inc(oe_low_cnt);
            oe_prev <= oe_pin;
        end
    end

    // ****************************************************************
    // supply handling
    // ****************************************************************
    // pump state with hysteresis between the two thresholds
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pump_run <= 1'b0;
            ldo_uv_off <= 1'b0;
        end else begin
            if (s[bss_pkg::CMP_BELOW_PUMP_START]) begin
                pump_run <= 1'b1;
            end else if (s[bss_pkg::CMP_ABOVE_PUMP_UPPER]) begin
                pump_run <= 1'b0;
            end
            if (s[bss_pkg::CMP_SUPPLY_UNDERVOLTAGE_LOCKOUT]) begin
                ldo_uv_off <= 1'b1;
            end else if (s_release) begin
                ldo_uv_off <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // fault flags and messages
    // ****************************************************************
    wire logic [5:0] cond = {s[bss_pkg::CMP_TEMP_WARN], s_severe,
                             s[bss_pkg::CMP_LDO_UV], s[bss_pkg::CMP_SUPPLY_OVERVOLTAGE_LOCKOUT],
                             s[bss_pkg::CMP_SUPPLY_UNDERVOLTAGE_LOCKOUT], s_hot};
    wire logic [5:0] new_evt = cond & ~flags;
    // set wins; oe rising clears only ended conditions
    wire logic [5:0] next_flags = cond | (flags & ~({NE{oe_rise}} & ~cond));
    wire logic [5:0] ack_clr = (msg_valid && msg_ack) ? 6'(1) << msg_code
                                                      : 6'h00;
    // one message per new event, none for severe undervoltage
    wire logic [5:0] next_pend = (pend & ~ack_clr) |
                                 (new_evt & bss_pkg::MSG_MASK);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags <= '0;
            pend <= '0;
        end else begin
            flags <= next_flags;
            pend <= next_pend;
        end
    end

    // message handshake towards the link transmitter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            msg_valid <= 1'b0;
            msg_code <= 3'h0;
        end else if (msg_valid) begin
            msg_valid <= !msg_ack;
        end else if (|pend && messaging_enable) begin
            msg_valid <= 1'b1;
            msg_code <= first_set(pend);
        end
    end

    // ****************************************************************
    // block enables
    // ****************************************************************
    wire logic off_state = state == bss_pkg::ST_SLEEP ||
                           state == bss_pkg::ST_SHUTDOWN;
    // lockout gates drivers, pump and bias; not the ldo
    wire logic next_bias = run_state && !lockout;
    wire logic next_gate = state == bss_pkg::ST_ACTIVE && !lockout;
    // ldo off in sleep, shutdown, undervoltage and late overtemperature
    wire logic next_ldo = !off_state && state != bss_pkg::ST_POR &&
                          !ldo_uv_off && !ldo_ot_off;
    wire logic next_msg_en = !off_state && !(ot_sent && !oe_pin);
    wire logic next_fault = state == bss_pkg::ST_POR ||
                            state == bss_pkg::ST_LDO_UP ||
                            |(flags & bss_pkg::FAULT_MASK);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pump_enable <= 1'b0;
            pump_bypass <= 1'b0;
            bias_reg_enable <= 1'b0;
            gate_drive_enable <= 1'b0;
            ldo_enable <= 1'b0;
            ldo_pulldown_enable <= 1'b0;
            messaging_enable <= 1'b0;
            bias_rail_ready_flag <= 1'b0;
            fault_oe_n <= 1'b0;
        end else begin
            pump_enable <= next_bias && pump_run;
            pump_bypass <= next_bias && !pump_run;
            bias_reg_enable <= next_bias;
            gate_drive_enable <= next_gate;
            ldo_enable <= next_ldo;
            ldo_pulldown_enable <= off_state;
            messaging_enable <= next_msg_en;
            bias_rail_ready_flag <= s_ready;
            fault_oe_n <= !next_fault;
        end
    end

    // fault pin only ever sinks
    assign fault_out = 1'b0;

    // ****************************************************************
    // register port
    // ****************************************************************
    wire logic wr_ctrl = reg_write && reg_addr == bss_pkg::REG_CTRL;
    wire logic [31:0] st0 = {26'h0, |(flags & bss_pkg::FAULT_MASK),
                             flags[bss_pkg::EVT_WARN],
                             flags[bss_pkg::EVT_SUPPLY_OVERVOLTAGE_LOCKOUT],
                             flags[bss_pkg::EVT_SUPPLY_UNDERVOLTAGE_LOCKOUT],
                             1'b0, flags[bss_pkg::EVT_OVER_TEMP]};
    wire logic [31:0] st1 = {30'h0, flags[bss_pkg::EVT_SEVERE_UV],
                             flags[bss_pkg::EVT_LDO_UV]};
    wire logic [31:0] rd_mux =
        reg_addr == bss_pkg::REG_CTRL ? {31'h0, sleep_cfg} :
        reg_addr == bss_pkg::REG_STATUS0 ? st0 :
        reg_addr == bss_pkg::REG_STATUS1 ? st1 :
        reg_addr == bss_pkg::REG_STATE ? {23'h0, bias_rail_ready_flag, state}
        : 32'h0000_0000;

    // sleep bit is forgotten across sleep and power-on
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sleep_cfg <= bss_pkg::CTRL_SLEEP_RESET;
            reg_rdata <= 32'h0000_0000;
        end else begin
            if (state == bss_pkg::ST_SLEEP || state == bss_pkg::ST_POR) begin
                sleep_cfg <= bss_pkg::CTRL_SLEEP_RESET;
            end else if (wr_ctrl) begin
                sleep_cfg <= reg_wdata[bss_pkg::CTRL_SLEEP_BIT];
            end
            reg_rdata <= reg_read ? rd_mux : 32'h0000_0000;
        end
    end
endmodule

// file: verilog/bss_cmp_if.sv
// raw and synchronised comparator levels between supervisor and synchroniser
// assumes the comparator outputs are asynchronous analog levels
`timescale 1ns/10ps
interface bss_cmp_if #(parameter int unsigned WIDTH = 11);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user_side (output raw, input sync);
endinterface

// file: verilog/bss_cmp_sync.sv
// two-stage synchroniser for the analog comparator outputs
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/10ps
module bss_cmp_sync #(
    parameter int unsigned WIDTH = 11
) (
    input wire logic clk_sys,
    input wire logic rst,
    bss_cmp_if.sync_side cmp
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    // first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= cmp.raw;
            stage2 <= stage1;
        end
    end

    assign cmp.sync = stage2;
endmodule

// file: verilog/bss_pkg.sv
// constants shared by the bias supervisor and its comparator synchroniser
// assumes a 200 MHz system clock and a plain register port
package bss_pkg;

    // clock rate and documented times
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned OE_LOW_US = 1000;
    localparam int unsigned BIAS_TIMEOUT_US = 15000;
    localparam int unsigned LDO_OFF_DELAY_US = 5000;
    localparam int unsigned OE_LOW_CYC = OE_LOW_US * CLK_MHZ;
    localparam int unsigned BIAS_TIMEOUT_CYC = BIAS_TIMEOUT_US * CLK_MHZ;
    localparam int unsigned LDO_OFF_CYC = LDO_OFF_DELAY_US * CLK_MHZ;
    localparam int unsigned TIMER_W = 22;

    // comparator lane positions
    localparam int unsigned NUM_CMP = 11;
    localparam int unsigned CMP_BELOW_PUMP_START = 0;
    localparam int unsigned CMP_ABOVE_PUMP_UPPER = 1;
    localparam int unsigned CMP_SUPPLY_UNDERVOLTAGE_LOCKOUT = 2;
    localparam int unsigned CMP_SUPPLY_OVERVOLTAGE_LOCKOUT = 3;
    localparam int unsigned CMP_SEVERE_UV = 4;
    localparam int unsigned CMP_ABOVE_RELEASE = 5;
    localparam int unsigned CMP_LDO_UV = 6;
    localparam int unsigned CMP_BIAS_READY = 7;
    localparam int unsigned CMP_OVER_TEMP = 8;
    localparam int unsigned CMP_TEMP_COOL = 9;
    localparam int unsigned CMP_TEMP_WARN = 10;

    // event flag positions, also the message codes
    localparam int unsigned NUM_EVT = 6;
    localparam int unsigned EVT_OVER_TEMP = 0;
    localparam int unsigned EVT_SUPPLY_UNDERVOLTAGE_LOCKOUT = 1;
    localparam int unsigned EVT_SUPPLY_OVERVOLTAGE_LOCKOUT = 2;
    localparam int unsigned EVT_LDO_UV = 3;
    localparam int unsigned EVT_SEVERE_UV = 4;
    localparam int unsigned EVT_WARN = 5;
    localparam logic [5:0] FAULT_MASK = 6'h1F;
    localparam logic [5:0] MSG_MASK = 6'h2F;
    localparam logic [5:0] LOCKOUT_MASK = 6'h0E;

    // register offsets and fields
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS0 = 8'h04;
    localparam logic [7:0] REG_STATUS1 = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0C;
    localparam int unsigned CTRL_SLEEP_BIT = 0;
    localparam logic CTRL_SLEEP_RESET = 1'b0;

    typedef enum logic [7:0] {
        ST_POR = 8'h01,
        ST_LDO_UP = 8'h02,
        ST_STANDBY = 8'h04,
        ST_BIAS_UP = 8'h08,
        ST_ACTIVE = 8'h10,
        ST_OVER_TEMP = 8'h20,
        ST_SLEEP = 8'h40,
        ST_SHUTDOWN = 8'h80
    } bss_state_t;

endpackage
